// [lps_pkg.sv]
// shared constants and types of the light and proximity sensor front end
package lps_pkg;
  localparam logic [6:0]  DEV_ADDR       = 7'h39;
  localparam int          CMD_BIT        = 7;
  localparam int          TYPE_MSB       = 6;
  localparam int          TYPE_LSB       = 5;
  localparam int          ADDR_MSB       = 4;
  localparam logic [1:0]  TYPE_REPEAT    = 2'h0;
  localparam logic [1:0]  TYPE_INCR      = 2'h1;
  localparam logic [1:0]  TYPE_SPECIAL   = 2'h3;
  localparam logic [4:0]  SF_NONE        = 5'h00;
  localparam logic [4:0]  SF_CLR_PROX    = 5'h05;
  localparam logic [4:0]  SF_CLR_AMB     = 5'h06;
  localparam logic [4:0]  SF_CLR_BOTH    = 5'h07;
  localparam int          REG_ENABLE     = 'h0;
  localparam int          REG_AMBIENT_INTEGRATION_TIME      = 'h1;
  localparam int          REG_PROX_INTEGRATION_TIME      = 'h2;
  localparam int          REG_WAIT_PERIOD      = 'h3;
  localparam int          REG_AMBIENT_LOW_THRESHOLD_LOW_BYTE      = 'h4;
  localparam int          REG_AMBIENT_LOW_THRESHOLD_HIGH_BYTE      = 'h5;
  localparam int          REG_AMBIENT_HIGH_THRESHOLD_LOW_BYTE      = 'h6;
  localparam int          REG_AMBIENT_HIGH_THRESHOLD_HIGH_BYTE      = 'h7;
  localparam int          REG_PROX_LOW_THRESHOLD_LOW_BYTE      = 'h8;
  localparam int          REG_PROX_LOW_THRESHOLD_HIGH_BYTE      = 'h9;
  localparam int          REG_PROX_HIGH_THRESHOLD_LOW_BYTE      = 'hA;
  localparam int          REG_PROX_HIGH_THRESHOLD_HIGH_BYTE      = 'hB;
  localparam int          NUM_REGS       = 12;
  localparam int          EN_PROX_INT    = 5;
  localparam int          EN_AMB_INT     = 4;
  localparam int          EN_WAIT        = 3;
  localparam int          EN_PROX        = 2;
  localparam int          EN_AMB         = 1;
  localparam int          EN_POWER       = 0;
  localparam logic [7:0]  RST_ENABLE     = 8'h00;
  localparam logic [7:0]  RST_AMBIENT_INTEGRATION_TIME      = 8'h00;
  localparam logic [7:0]  RST_PROX_INTEGRATION_TIME      = 8'hFF;
  localparam logic [7:0]  RST_WAIT_PERIOD      = 8'hFF;
  localparam logic [7:0]  RST_THRESH     = 8'h00;
  localparam int          STEP_TIME_NS   = 2720000;
  localparam int          SYS_CLK_MHZ    = 200;
  localparam int          STEP_CYCLES    = (STEP_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int          LONG_WAIT_MULT = 12;
  localparam logic [8:0]  STEP_SPAN      = 9'h100;
  localparam logic [9:0]  STEP_FULL_LOW  = 10'h3FF;
  localparam logic [15:0] FULL_SCALE_MAX = 16'hFFFF;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_WARM = 3'b001,
    SEQ_AMB  = 3'b010,
    SEQ_PROX = 3'b011,
    SEQ_WAIT = 3'b100
  } lps_seq_state_t;
  typedef enum logic [2:0] {
    BUS_IDLE      = 3'b000,
    BUS_ADDR      = 3'b001,
    BUS_ADDR_ACK  = 3'b010,
    BUS_WRITE     = 3'b011,
    BUS_WRITE_ACK = 3'b100,
    BUS_READ      = 3'b101,
    BUS_READ_ACK  = 3'b110
  } lps_bus_state_t;
endpackage : lps_pkg

// [lps_seq_if.sv]
`timescale 1ns/10ps
// settings and state passed between the register front end and the sequencer
interface lps_seq_if;
  logic                    power_on;
  logic                    ambient_enable;
  logic                    prox_enable;
  logic                    wait_enable;
  logic                    long_wait_scale;
  logic [7:0]              ambient_integration_time;
  logic [7:0]              prox_integration_time;
  logic [7:0]              wait_period;
  lps_pkg::lps_seq_state_t state;
  logic [15:0]             ambient_full_scale;
  modport regs (output power_on, ambient_enable, prox_enable, wait_enable, long_wait_scale,
                output ambient_integration_time, prox_integration_time, wait_period,
                input state, ambient_full_scale);
  modport seq (input power_on, ambient_enable, prox_enable, wait_enable, long_wait_scale,
               input ambient_integration_time, prox_integration_time, wait_period,
               output state, ambient_full_scale);
endinterface : lps_seq_if

// [lps_seq.sv]
`timescale 1ns/10ps
// measurement sequencer: warm-up delay, ambient, proximity and wait phases
module lps_seq #(
  parameter int STEP_CYC = lps_pkg::STEP_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  lps_seq_if.seq    sq
);
  import lps_pkg::*;

  typedef struct packed {
    lps_seq_state_t state;
    logic [19:0]    tick;
    logic [11:0]    steps;
    logic [15:0]    full_scale;
  } lps_seq_regs_t;

  lps_seq_regs_t  cur;
  lps_seq_regs_t  next_cur;
  logic           last_step;
  lps_seq_state_t to_prox;
  lps_seq_state_t dest;
  logic [18:0]    amb_fs;
  logic [11:0]    amb_span;

  // steps of one phase: 256 minus the register value
  function automatic logic [11:0] lps_span(input logic [7:0] v);
    return 12'(STEP_SPAN - {1'b0, v});
  endfunction : lps_span

  // phase chaining and step counting
  always_comb begin
    next_cur  = cur;
    last_step = cur.tick == 20'(STEP_CYC - 1) && cur.steps == 12'h001;
    to_prox   = sq.prox_enable ? SEQ_PROX : (sq.wait_enable ? SEQ_WAIT : SEQ_WARM);
    amb_span  = lps_span(sq.ambient_integration_time);
    // [RULE16] full scale per step
    amb_fs    = {9'(amb_span - 12'h001), STEP_FULL_LOW}; // steps times 1024, minus one
    next_cur.full_scale = (amb_fs[18:16] != 3'h0) ? FULL_SCALE_MAX : amb_fs[15:0];
    next_cur.tick = (cur.tick == 20'(STEP_CYC - 1)) ? 20'h0 : cur.tick + 20'h1;
    dest = cur.state;
    case (cur.state)
      SEQ_WARM: dest = (sq.ambient_enable && sq.power_on) ? SEQ_AMB : to_prox;
      SEQ_AMB:  dest = to_prox;
      SEQ_PROX: dest = sq.wait_enable ? SEQ_WAIT : SEQ_WARM;
      SEQ_WAIT: dest = SEQ_WARM;
      default:  dest = SEQ_WARM;
    endcase
    // [RULE11] power gates the whole cycle
    if (!sq.power_on) begin
      next_cur.state = SEQ_IDLE;
      next_cur.tick  = 20'h0;
    end else if (cur.state == SEQ_IDLE || last_step) begin
      // [RULE12] warm step before each converter cycle
      next_cur.state = (cur.state == SEQ_IDLE) ? SEQ_WARM : dest;
      next_cur.tick  = 20'h0;
      case (next_cur.state)
        SEQ_AMB:  next_cur.steps = amb_span;
        SEQ_PROX: next_cur.steps = lps_span(sq.prox_integration_time);
        // [RULE18] wait length and long scale
        SEQ_WAIT: next_cur.steps = sq.long_wait_scale ?
                    12'(lps_span(sq.wait_period) * LONG_WAIT_MULT) : lps_span(sq.wait_period);
        default:  next_cur.steps = 12'h001;
      endcase
    end else if (cur.tick == 20'(STEP_CYC - 1)) begin
      next_cur.steps = cur.steps - 12'h001;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sq.state              = cur.state;
  assign sq.ambient_full_scale = cur.full_scale;

  // [RULE15] power-up always passes through warm
  a_warm_after_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE15]
    ($past(cur.state) == SEQ_IDLE && cur.state != SEQ_IDLE) |-> cur.state == SEQ_WARM)
    else $error("sequencer left idle without warm-up");
  // [RULE13] ambient needs both enables
  a_amb_needs_power: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
    $rose(cur.state == SEQ_AMB) |-> $past(sq.ambient_enable && sq.power_on)
      && $past(cur.state) == SEQ_WARM)
    else $error("ambient phase entered without enables");
endmodule : lps_seq

// [lps_ctrl_regs.sv]
`timescale 1ns/10ps
// register front end: serial slave, control registers, interrupt flags
// How it works
// [RULE1] host marks every command byte with bit 7 set
// [RULE2] bits 6:5 pick transfer type; 00 repeats the same register
// [RULE3] type 01 steps the register pointer after each data byte
// [RULE4] bits 4:0 are the register address or the special code
// [RULE5] codes 05, 06, 07 clear proximity, ambient, both; 00 does nothing
// [RULE6] interrupt clear is a one-shot, no write back needed
// [RULE7] enable bits 5 and 4 gate proximity and ambient interrupts
// [RULE8] enable bit 3 switches the wait timer
// [RULE9] enable bit 2 switches the proximity phase
// [RULE10] enable bit 1 switches the ambient converter
// [RULE11] enable bit 0 runs the oscillator and timers
// [RULE12] one fixed 2.72 ms step precedes each converter cycle
// [RULE13] ambient runs only with ambient enable and power on
// [RULE14] oscillator kept running during any serial transfer
// [RULE15] no measurement until 2.72 ms after power on
// [RULE16] ambient time is 256 minus value steps; full scale capped
// [RULE17] host should program proximity time to one step
// [RULE18] wait is 256 minus value steps, twelve times when long
// [RULE19] host avoids single-byte write of wait above 127
// [RULE20] host loads wait before enabling proximity or ambient
// [RULE21] ambient interrupt when channel zero leaves its threshold window
// [RULE22] proximity interrupt when result leaves its threshold window
// [RULE23] slave answers only at bus address 0x39
// [RULE24] transfers without command use the stored pointer
// [RULE25] raised interrupt holds until its clear command
module lps_ctrl_regs #(
  parameter int STEP_CYC = lps_pkg::STEP_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        conv_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             int_out,
  output logic             int_oe_n,
  input  wire logic        long_wait_scale,
  input  wire logic        conv_valid,
  input  wire logic        conv_is_prox,
  input  wire logic [15:0] conv_value,
  output logic             osc_run,
  output logic             ambient_active,
  output logic             prox_active,
  output logic             wait_active,
  output logic [15:0]      ambient_full_scale
);
  import lps_pkg::*;

  typedef struct packed {
    logic [2:0]               scl_s;
    logic [2:0]               sda_s;
    logic [1:0]               lw_s;
    logic [2:0]               tg_s;
    lps_bus_state_t           bus;
    logic [2:0]               bitc;
    logic [7:0]               shreg;
    logic                     ackd;
    logic                     rw;
    logic                     first;
    logic                     busy;
    logic [4:0]               ptr;
    logic [1:0]               xtype;
    logic [NUM_REGS-1:0][7:0] regs;
    logic                     amb_pend;
    logic                     prox_pend;
    logic                     pin_low;
    logic                     sda_oe_n;
    logic                     int_oe_n;
    logic                     osc_run;
    logic                     amb_act;
    logic                     prox_act;
    logic                     wait_act;
    logic [15:0]              fs;
  } lps_sys_regs_t;

  typedef struct packed {
    logic [15:0] val;
    logic        prox;
    logic        tog;
  } lps_link_regs_t;

  lps_sys_regs_t  cur;
  lps_sys_regs_t  next_cur;
  lps_link_regs_t lk;
  lps_link_regs_t next_lk;
  logic [1:0]     rst_pipe;
  logic [1:0]     crst_pipe;
  logic           rst_n;
  logic           crst_n;
  logic           sda_bit;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_cond;
  logic           stop_cond;
  logic [7:0]     wbyte;
  logic [7:0]     rd_data;
  logic           wr_done;
  logic           is_cmd;
  logic           is_special;
  logic           clr_amb;
  logic           clr_prox;
  logic           res_new;
  logic           amb_out;
  logic           prox_out;
  logic           do_load;

  lps_seq_if sq ();

  // reset release, one pipe per clock domain
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  always_ff @(posedge conv_clk or negedge reset_n) begin
    if (!reset_n) begin
      crst_pipe <= 2'h0;
    end else begin
      crst_pipe <= {crst_pipe[0], 1'b1};
    end
  end

  assign rst_n  = rst_pipe[1];
  assign crst_n = crst_pipe[1];

  // converter side: capture each result and flip a toggle for the crossing
  always_comb begin
    next_lk = lk;
    if (conv_valid) begin
      next_lk.val  = conv_value;
      next_lk.prox = conv_is_prox;
      next_lk.tog  = ~lk.tog;
    end
  end

  always_ff @(posedge conv_clk or negedge crst_n) begin
    if (!crst_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // serial line events from the synchronised pins
  assign sda_bit    = cur.sda_s[1];
  assign scl_rise   = cur.scl_s[1] & ~cur.scl_s[2];
  assign scl_fall   = ~cur.scl_s[1] & cur.scl_s[2];
  assign start_cond = cur.scl_s[1] & cur.scl_s[2] & cur.sda_s[2] & ~sda_bit;
  assign stop_cond  = cur.scl_s[1] & cur.scl_s[2] & ~cur.sda_s[2] & sda_bit;
  assign wbyte      = {cur.shreg[6:0], sda_bit};
  assign wr_done    = cur.bus == BUS_WRITE && scl_rise && cur.bitc == 3'h7 && !start_cond;
  // [RULE1] command bytes carry bit 7
  assign is_cmd     = wr_done && cur.first && wbyte[CMD_BIT];
  assign is_special = is_cmd && wbyte[TYPE_MSB:TYPE_LSB] == TYPE_SPECIAL;
  // [RULE5] special codes select which flag to clear
  assign clr_prox   = is_special && (wbyte[ADDR_MSB:0] == SF_CLR_PROX ||
                                     wbyte[ADDR_MSB:0] == SF_CLR_BOTH);
  assign clr_amb    = is_special && (wbyte[ADDR_MSB:0] == SF_CLR_AMB ||
                                     wbyte[ADDR_MSB:0] == SF_CLR_BOTH);
  assign rd_data    = (cur.ptr < 5'(NUM_REGS)) ? cur.regs[cur.ptr] : 8'h00;

  // result arrival and threshold windows
  assign res_new  = cur.tg_s[2] ^ cur.tg_s[1];
  // [RULE21] ambient channel zero window
  assign amb_out  = lk.val < {cur.regs[REG_AMBIENT_LOW_THRESHOLD_HIGH_BYTE], cur.regs[REG_AMBIENT_LOW_THRESHOLD_LOW_BYTE]} ||
                    lk.val > {cur.regs[REG_AMBIENT_HIGH_THRESHOLD_HIGH_BYTE], cur.regs[REG_AMBIENT_HIGH_THRESHOLD_LOW_BYTE]};
  // [RULE22] proximity window
  assign prox_out = lk.val < {cur.regs[REG_PROX_LOW_THRESHOLD_HIGH_BYTE], cur.regs[REG_PROX_LOW_THRESHOLD_LOW_BYTE]} ||
                    lk.val > {cur.regs[REG_PROX_HIGH_THRESHOLD_HIGH_BYTE], cur.regs[REG_PROX_HIGH_THRESHOLD_LOW_BYTE]};

  // next state of the register front end
  always_comb begin
    next_cur       = cur;
    do_load        = 1'b0;
    next_cur.scl_s = {cur.scl_s[1:0], scl_in};
    next_cur.sda_s = {cur.sda_s[1:0], sda_in};
    next_cur.lw_s  = {cur.lw_s[0], long_wait_scale};
    next_cur.tg_s  = {cur.tg_s[1:0], lk.tog};
    if (start_cond) begin
      next_cur.bus      = BUS_ADDR;
      next_cur.bitc     = 3'h0;
      next_cur.sda_oe_n = 1'b1;
      next_cur.busy     = 1'b1;
    end else if (stop_cond) begin
      next_cur.bus      = BUS_IDLE;
      next_cur.sda_oe_n = 1'b1;
      next_cur.busy     = 1'b0;
    end else begin
      case (cur.bus)
        BUS_IDLE: ;
        BUS_ADDR: if (scl_rise) begin
          next_cur.shreg = wbyte;
          next_cur.bitc  = cur.bitc + 3'h1;
          if (cur.bitc == 3'h7) begin
            next_cur.ackd = 1'b0;
            next_cur.rw   = sda_bit;
            // [RULE23] only our address is acknowledged
            next_cur.bus  = (cur.shreg[6:0] == DEV_ADDR) ? BUS_ADDR_ACK : BUS_IDLE;
          end
        end
        BUS_ADDR_ACK, BUS_WRITE_ACK: if (scl_fall) begin
          // pull low for the ack bit, let go on the following fall
          next_cur.ackd     = ~cur.ackd;
          next_cur.sda_oe_n = cur.ackd;
          if (cur.ackd) begin
            next_cur.bitc  = 3'h0;
            next_cur.first = cur.bus == BUS_ADDR_ACK;
            if (cur.bus == BUS_ADDR_ACK && cur.rw) begin
              do_load = 1'b1;
            end else begin
              next_cur.bus = BUS_WRITE;
            end
          end
        end
        BUS_WRITE: if (scl_rise) begin
          next_cur.shreg = wbyte;
          next_cur.bitc  = cur.bitc + 3'h1;
          if (cur.bitc == 3'h7) begin
            next_cur.bus   = BUS_WRITE_ACK;
            next_cur.ackd  = 1'b0;
            next_cur.first = 1'b0;
            if (is_cmd) begin
              // [RULE4] address field kept unless special
              if (!is_special) begin
                next_cur.ptr   = wbyte[ADDR_MSB:0];
                next_cur.xtype = wbyte[TYPE_MSB:TYPE_LSB];
              end
            end else begin
              // [RULE24] data goes to the stored pointer
              if (cur.ptr < 5'(NUM_REGS)) begin
                next_cur.regs[cur.ptr] = wbyte;
              end
              // [RULE3] auto increment steps the pointer
              if (cur.xtype == TYPE_INCR) begin
                next_cur.ptr = cur.ptr + 5'h01;
              end
            end
          end
        end
        BUS_READ: if (scl_rise) begin
          next_cur.bitc = cur.bitc + 3'h1;
          if (cur.bitc == 3'h7) begin
            next_cur.bus  = BUS_READ_ACK;
            next_cur.ackd = 1'b0;
          end
        end else if (scl_fall) begin
          next_cur.shreg    = {cur.shreg[6:0], 1'b0};
          next_cur.sda_oe_n = cur.shreg[6];
        end
        BUS_READ_ACK: if (scl_rise) begin
          // master ack asks for another byte, nack ends the read
          if (sda_bit) begin
            next_cur.bus = BUS_IDLE;
          end else begin
            next_cur.ackd = 1'b1;
          end
        end else if (scl_fall) begin
          if (cur.ackd) begin
            do_load = 1'b1;
          end else begin
            next_cur.sda_oe_n = 1'b1;
          end
        end
        default: next_cur.bus = BUS_IDLE;
      endcase
    end
    // load a read byte, driving its first bit at once
    if (do_load) begin
      next_cur.bus      = BUS_READ;
      next_cur.bitc     = 3'h0;
      next_cur.shreg    = rd_data;
      next_cur.sda_oe_n = rd_data[7];
      if (cur.xtype == TYPE_INCR) begin
        next_cur.ptr = cur.ptr + 5'h01;
      end
    end
    // [RULE6] [RULE7] [RULE25] sticky flags, set beats clear
    next_cur.amb_pend  = (cur.amb_pend & ~clr_amb) |
                         (res_new & ~lk.prox & cur.regs[REG_ENABLE][EN_AMB_INT] & amb_out);
    next_cur.prox_pend = (cur.prox_pend & ~clr_prox) |
                         (res_new & lk.prox & cur.regs[REG_ENABLE][EN_PROX_INT] & prox_out);
    next_cur.int_oe_n  = ~(cur.amb_pend | cur.prox_pend);
    // [RULE14] oscillator forced on while the bus is busy
    next_cur.osc_run   = cur.regs[REG_ENABLE][EN_POWER] | cur.busy;
    next_cur.amb_act   = sq.state == SEQ_AMB;
    next_cur.prox_act  = sq.state == SEQ_PROX;
    next_cur.wait_act  = sq.state == SEQ_WAIT;
    next_cur.fs        = sq.ambient_full_scale;
  end

  // register update of the front end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur                     <= '0;
      cur.regs[REG_ENABLE]    <= RST_ENABLE;
      cur.regs[REG_AMBIENT_INTEGRATION_TIME]     <= RST_AMBIENT_INTEGRATION_TIME;
      cur.regs[REG_PROX_INTEGRATION_TIME]     <= RST_PROX_INTEGRATION_TIME;
      cur.regs[REG_WAIT_PERIOD]     <= RST_WAIT_PERIOD;
      for (int i = REG_AMBIENT_LOW_THRESHOLD_LOW_BYTE; i < NUM_REGS; i++) begin
        cur.regs[i] <= RST_THRESH;
      end
      cur.sda_oe_n            <= 1'b1;
      cur.int_oe_n            <= 1'b1;
      // pin samples start at the idle-high level, so no false edge follows reset
      cur.scl_s               <= 3'h7;
      cur.sda_s               <= 3'h7;
    end else begin
      cur <= next_cur;
    end
  end

  // [RULE8] [RULE9] [RULE10] [RULE11] enable bits steer the sequencer
  assign sq.power_on                 = cur.regs[REG_ENABLE][EN_POWER];
  assign sq.ambient_enable           = cur.regs[REG_ENABLE][EN_AMB];
  assign sq.prox_enable              = cur.regs[REG_ENABLE][EN_PROX];
  assign sq.wait_enable              = cur.regs[REG_ENABLE][EN_WAIT];
  assign sq.long_wait_scale          = cur.lw_s[1];
  assign sq.ambient_integration_time = cur.regs[REG_AMBIENT_INTEGRATION_TIME];
  assign sq.prox_integration_time    = cur.regs[REG_PROX_INTEGRATION_TIME];
  assign sq.wait_period              = cur.regs[REG_WAIT_PERIOD];

  lps_seq #(
    .STEP_CYC (STEP_CYC)
  ) u_seq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sq      (sq)
  );

  // pins and status outputs
  assign sda_out            = cur.pin_low;
  assign sda_oe_n           = cur.sda_oe_n;
  assign int_out            = cur.pin_low;
  assign int_oe_n           = cur.int_oe_n;
  assign osc_run            = cur.osc_run;
  assign ambient_active     = cur.amb_act;
  assign prox_active        = cur.prox_act;
  assign wait_active        = cur.wait_act;
  assign ambient_full_scale = cur.fs;

  // [RULE4] command loads pointer
  a_cmd_loads_ptr: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    (is_cmd && !is_special) |=> cur.ptr == $past(wbyte[ADDR_MSB:0]))
    else $error("command did not load pointer");
  // [RULE3] data write steps pointer
  a_incr_ptr: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    (wr_done && !is_cmd && cur.xtype == TYPE_INCR) |=> cur.ptr == $past(cur.ptr) + 5'h01)
    else $error("auto increment missed");
  // [RULE2] repeat type keeps pointer
  a_repeat_ptr: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    (wr_done && !is_cmd && cur.xtype == TYPE_REPEAT) |=> $stable(cur.ptr))
    else $error("repeat type moved pointer");
  // [RULE6] clear both empties the flags
  a_sf_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
    (clr_amb && clr_prox && !res_new) |=> !cur.amb_pend && !cur.prox_pend ##1 cur.int_oe_n)
    else $error("interrupt clear failed");
  // [RULE7] disabled ambient interrupt never rises
  a_amb_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    (!cur.regs[REG_ENABLE][EN_AMB_INT] && !cur.amb_pend) |=> !cur.amb_pend)
    else $error("ambient flag set while disabled");
  // [RULE25] flag holds until cleared
  a_int_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE25]
    (cur.prox_pend && !clr_prox) |=> cur.prox_pend ##1 !cur.int_oe_n)
    else $error("proximity flag dropped on its own");
  // [RULE14] busy bus keeps oscillator on
  a_osc_busy: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
    cur.busy |=> cur.osc_run)
    else $error("oscillator stopped during transfer");
  // [RULE23] foreign address is ignored
  a_addr_match: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE23]
    (cur.bus == BUS_ADDR && scl_rise && cur.bitc == 3'h7 && !start_cond && !stop_cond
      && cur.shreg[6:0] != DEV_ADDR) |=> cur.bus == BUS_IDLE ##1 cur.sda_oe_n)
    else $error("answered a foreign address");
endmodule : lps_ctrl_regs

// [lps_host.sv]
`timescale 1ns/10ps
// serial bus host model: drives clock and data, releases data high
module lps_host (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda
);
  initial {scl, sda} = 2'b11;
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask : tk
  // s=1 start or repeated start, s=0 stop; phases of 6 cycles
  task automatic cond(input logic s);
    sda = s; tk(6);
    scl = 1'b1; tk(6);
    sda = ~s; tk(6);
    scl = ~s;
  endtask : cond
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] o, input logic ma, output logic [7:0] i,
                      output logic sa);
    for (int k = 7; k >= -1; k--) begin
      sda = (k < 0) ? ma : o[k]; tk(6);
      scl = 1'b1; tk(3);
      if (k < 0) sa = sda_w;
      else i[k] = sda_w;
      tk(3); scl = 1'b0;
    end
  endtask : xfer
endmodule : lps_host

// [tb.sv]
`timescale 1ns/10ps
// bench of the register front end
module tb;
  logic        sys_clk = 1'b0;
  logic        conv_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cv = 1'b0;
  logic        cp = 1'b0;
  logic [15:0] cval = 16'h0000;
  logic        scl, sda_m, sda_out, sda_oe_n, int_oe_n, osc_run, ip, aa;
  logic        lws = 1'b0;
  logic [15:0] afs;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  wire logic   sda_w = sda_m & (sda_oe_n | sda_out);
  always #2.5 sys_clk = ~sys_clk;
  initial #1.3 forever #7.5 conv_clk = ~conv_clk;
  lps_host lps_host_i (.clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda(sda_m));
  lps_ctrl_regs #(.STEP_CYC(20)) lps_ctrl_regs_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .conv_clk(conv_clk), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_out(ip), .int_oe_n(int_oe_n), .long_wait_scale(lws),
    .conv_valid(cv), .conv_is_prox(cp), .conv_value(cval), .osc_run(osc_run),
    .ambient_active(aa), .prox_active(), .wait_active(), .ambient_full_scale(afs));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // address, command, then n data bytes low first; every byte acked
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    logic [7:0] x;
    logic       a;
    lps_host_i.cond(1'b1);
    for (int k = -1; k <= n; k++) begin
      lps_host_i.xfer((k < 0) ? 8'h72 : (k == 0) ? c : d[8*k-8 +: 8], 1'b1, x, a);
      chk("ack", 16'h0000, 16'(a));
    end
    lps_host_i.cond(1'b0);
  endtask : wr
  // optional command, then read of n bytes, last one refused
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v);
    logic [7:0] x;
    logic       a;
    v = 16'h0000;
    if (c[7]) wr(c, 16'h0000, 0);
    lps_host_i.cond(1'b1);
    for (int k = -1; k < n; k++) begin
      lps_host_i.xfer((k < 0) ? 8'h73 : 8'hFF, k < 0 || k == n - 1, x, a);
      if (k >= 0) v[8*k +: 8] = x;
      else chk("rd ack", 16'h0000, 16'(a));
    end
    lps_host_i.cond(1'b0);
  endtask : rd
  // one result on the converter clock
  task automatic res(input logic p, input logic [15:0] v);
    @(negedge conv_clk);
    {cv, cp, cval} = {1'b1, p, v};
    @(negedge conv_clk);
    cv = 1'b0;
    repeat (12) @(negedge sys_clk);
  endtask : res
  task automatic t_regs();
    logic [15:0] v;
    logic [7:0]  x;
    logic        a;
    chk("fs reset", 16'hFFFF, afs);
    rd(8'hA2, 2, v);
    chk("prox_integration_time wait_period", 16'hFFFF, v);
    wr(8'h81, 16'h00F6, 1);
    chk("full scale", 16'h27FF, afs);
    wr(8'hA4, 16'h0010, 2);
    wr(8'hA6, 16'h0100, 2);
    rd(8'hA4, 2, v);
    chk("amb low", 16'h0010, v);
    rd(8'h84, 2, v);
    chk("repeat", 16'h1010, v);
    rd(8'h00, 1, v);
    chk("stored ptr", 16'h0010, v);
    lps_host_i.cond(1'b1);
    lps_host_i.xfer(8'h74, 1'b1, x, a);
    chk("foreign", 16'h0001, 16'(a));
    lps_host_i.cond(1'b0);
  endtask : t_regs
  task automatic t_int();
    logic [15:0] v;
    wr(8'hA2, 16'h10FF, 2);
    rd(8'hA2, 2, v);
    chk("wait loaded", 16'h10FF, v);
    wr(8'h80, 16'h0013, 1);
    chk("osc on", 16'h0001, 16'(osc_run));
    chk("amb active", 16'h0001, 16'(aa));
    res(1'b0, 16'h0200);
    chk("amb int", 16'h0000, 16'(int_oe_n));
    res(1'b0, 16'h0050);
    chk("int held", 16'h0000, 16'(int_oe_n));
    wr(8'hE6, 16'h0000, 0);
    chk("amb clr", 16'h0001, 16'(int_oe_n));
    res(1'b1, 16'h0200);
    chk("prox gated", 16'h0001, 16'(int_oe_n));
    wr(8'h80, 16'h0020, 1);
    chk("amb stopped", 16'h0000, 16'(aa));
    res(1'b1, 16'h0200);
    chk("prox int", 16'h0000, 16'(int_oe_n));
    wr(8'hE7, 16'h0000, 0);
    chk("both clr", 16'h0001, 16'(int_oe_n));
    chk("osc off", 16'h0000, 16'(osc_run));
    lps_host_i.cond(1'b1);
    chk("osc busy", 16'h0001, 16'(osc_run));
    lps_host_i.cond(1'b0);
    chk("int pin", 16'h0000, 16'(ip));
  endtask : t_int
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_regs();
    t_int();
    stop_test();
  end
endmodule : tb
